// ===== common/enc_pin_pkg.sv
/*
 * Constants, register map and types for the encoder feedback and multi-function pin block.
 * Assumes a 50 MHz system clock and a plain single-cycle register port.
 */
package enc_pin_pkg;
   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_MHZ = 50;
   localparam int SER_HALF_NS = 500;
   localparam int SER_HALF_CYC = (SER_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int SER_REST_NS = 20000;
   localparam int SER_REST_CYC = (SER_REST_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_PULSE_NS = 1000;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 11;
   localparam int SER_BITS = 24;
   localparam int BITS_W = 5;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_MAIN_POS = 8'h04;
   localparam logic [7:0] OFS_GEN_INPUTS = 8'h08;
   localparam logic [7:0] OFS_STEP_CMD = 8'h0c;
   localparam logic [7:0] OFS_SER_CTRL = 8'h10;
   localparam logic [7:0] OFS_MAIN_SER_POS = 8'h14;
   localparam logic [7:0] OFS_AUX_SER_POS = 8'h18;
   localparam int CFG_ENC_MODE_BIT = 0;
   localparam int CFG_SER_EN_BIT = 1;
   localparam int CFG_MT_LSB = 2;
   localparam int MT_W = 3;
   localparam logic [4:0] CFG_RESET = 5'h00;
   localparam int GEN_IN81_BIT = 0;
   localparam int GEN_IN82_BIT = 1;
   localparam int STEP_FIRE_BIT = 0;
   localparam int STEP_DIR_BIT = 1;
   localparam int SER_MAIN_BIT = 0;
   localparam int SER_AUX_BIT = 1;
   localparam int SER_OPT_BIT = 2;

   // ************************************************************
   // Motor type codes that select stepper operation
   // ************************************************************
   localparam logic [2:0] MT_STEP_P2 = 3'h2;
   localparam logic [2:0] MT_STEP_M2 = 3'h3;
   localparam logic [2:0] MT_STEP_P25 = 3'h4;
   localparam logic [2:0] MT_STEP_M25 = 3'h5;

   typedef enum logic {ENC_QUAD, ENC_PULSE_DIR} enc_mode_t;
   typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_REST} ser_state_t;
endpackage : enc_pin_pkg

// ===== common/ser_if.sv
/*
 * Carrier between the pin router and one serial absolute-encoder engine.
 * Assumes the data line is already synchronised by the router.
 */
`timescale 1ns/100ps
interface ser_if;
   import enc_pin_pkg::*;
   logic start;
   logic sdata;
   logic sclk;
   logic busy;
   logic done;
   logic [SER_BITS-1:0] word;
   modport ctrl (output start, output sdata, input sclk, input busy, input done, input word);
   modport engine (input start, input sdata, output sclk, output busy, output done,
      output word);
endinterface : ser_if

// ===== verilog/ser_reader.sv
/*
 * One serial absolute-encoder reader: clocks out a burst and shifts in a position word.
 * Assumes start is a one-cycle pulse and sdata has passed a two-stage synchroniser.
 */
`timescale 1ns/100ps
module ser_reader
   import enc_pin_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   ser_if.engine s
);
   ser_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [BITS_W-1:0] bits_r, bits_nxt;
   logic [SER_BITS-1:0] shift_r, shift_nxt;
   logic [SER_BITS-1:0] word_r, word_nxt;
   logic sclk_r, sclk_nxt;
   logic done_r, done_nxt;

   // ************************************************************
   // Burst sequencer
   // ************************************************************
   // The clock idles high; data are taken as the clock rises, MSB first.
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      bits_nxt = bits_r;
      shift_nxt = shift_r;
      word_nxt = word_r;
      done_nxt = 1'b0;
      case (state_r)
         S_IDLE:
         begin
            if (s.start)
            begin
               state_nxt = S_LOW;
               cnt_nxt = '0;
               bits_nxt = '0;
            end
         end
         S_LOW:
         begin
            if (cnt_r == CNT_W'(SER_HALF_CYC - 1))
            begin
               state_nxt = S_HIGH;
               cnt_nxt = '0;
               shift_nxt = {shift_r[SER_BITS-2:0], s.sdata};
               bits_nxt = bits_r + 1'b1;
            end
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         S_HIGH:
         begin
            if (cnt_r == CNT_W'(SER_HALF_CYC - 1))
            begin
               cnt_nxt = '0;
               if (bits_r == BITS_W'(SER_BITS))
               begin
                  state_nxt = S_REST;
                  word_nxt = shift_r;
                  done_nxt = 1'b1;
               end
               else
                  state_nxt = S_LOW;
            end
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         S_REST:
         begin
            // The encoder needs a quiet high clock before the next burst.
            if (cnt_r == CNT_W'(SER_REST_CYC - 1))
            begin
               state_nxt = S_IDLE;
               cnt_nxt = '0;
            end
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         default:
            state_nxt = S_IDLE;
      endcase
      sclk_nxt = (state_nxt != S_LOW);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         state_r <= S_IDLE;
         cnt_r <= '0;
         bits_r <= '0;
         shift_r <= '0;
         word_r <= '0;
         sclk_r <= 1'b1;
         done_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         bits_r <= bits_nxt;
         shift_r <= shift_nxt;
         word_r <= word_nxt;
         sclk_r <= sclk_nxt;
         done_r <= done_nxt;
      end
   end

   assign s.sclk = sclk_r;
   assign s.busy = (state_r != S_IDLE);
   assign s.done = done_r;
   assign s.word = word_r;
endmodule : ser_reader

// ===== verilog/enc_pin_top.sv
/*
 * Feedback inputs and multi-function pin routing of a single-axis motion controller.
 * Assumes a 50 MHz clock; every pin input is asynchronous and is synchronised here.
 */
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module enc_pin_top
   import enc_pin_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [DATA_W-1:0] rdata,
   input wire logic main_enc_chan_a,
   input wire logic main_enc_chan_b,
   input wire logic aux_enc_chan_a,
   input wire logic aux_enc_chan_b,
   input wire logic serial_encoder_option,
   input wire logic multi_pin_one_in,
   output logic multi_pin_two_out,
   output logic multi_pin_two_oe,
   input wire logic multi_pin_three_in,
   output logic multi_pin_four_out,
   output logic multi_pin_four_oe
);
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   localparam int SYNC_W = 7;
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   logic pa_r, pb_r;
   logic ma, mb, aa, ab, d1, d3, opt;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         pa_r <= 1'b0;
         pb_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {serial_encoder_option, multi_pin_three_in, multi_pin_one_in,
            aux_enc_chan_b, aux_enc_chan_a, main_enc_chan_b, main_enc_chan_a};
         sync2_r <= sync1_r;
         pa_r <= sync2_r[0];
         pb_r <= sync2_r[1];
      end
   end
   assign {opt, d3, d1, ab, aa, mb, ma} = sync2_r;

   // ************************************************************
   // Configuration and mode decode
   // ************************************************************
   logic [4:0] cfg_r, cfg_nxt;
   enc_mode_t enc_mode;
   logic [MT_W-1:0] motor_type_setting;
   logic stepper, ser_active;

   assign enc_mode = enc_mode_t'(cfg_r[CFG_ENC_MODE_BIT]);
   assign motor_type_setting = cfg_r[CFG_MT_LSB +: MT_W];
   assign stepper = (motor_type_setting == MT_STEP_P2) || (motor_type_setting == MT_STEP_M2)
      || (motor_type_setting == MT_STEP_P25) || (motor_type_setting == MT_STEP_M25);
   // Stepper wins the pins: the two uses cannot share pin two and four.
   assign ser_active = opt && cfg_r[CFG_SER_EN_BIT] && !stepper;

   // ************************************************************
   // Main encoder counter
   // ************************************************************
   logic [DATA_W-1:0] pos_r, pos_nxt;
   logic one_change, quad_up;

   assign one_change = (ma ^ pa_r) ^ (mb ^ pb_r);
   assign quad_up = ~(pa_r ^ mb);

   always_comb
   begin
      pos_nxt = pos_r;
      if (enc_mode == ENC_QUAD)
      begin
         // A double change is a lost edge; it is dropped rather than guessed.
         if (one_change)
            pos_nxt = quad_up ? pos_r + 1'b1 : pos_r - 1'b1;
      end
      else if (ma && !pa_r)
         pos_nxt = mb ? pos_r + 1'b1 : pos_r - 1'b1;
   end

   // ************************************************************
   // Serial encoder engines
   // ************************************************************
   ser_if ser_main ();
   ser_if ser_aux ();
   logic wr_ser;

   assign wr_ser = wr_stb && (addr == OFS_SER_CTRL);
   assign ser_main.start = wr_ser && wdata[SER_MAIN_BIT] && ser_active;
   assign ser_main.sdata = d1;
   assign ser_aux.start = wr_ser && wdata[SER_AUX_BIT] && ser_active;
   assign ser_aux.sdata = d3;

   ser_reader main_reader (.clock(clock), .rst_b(rst_b), .s(ser_main));
   ser_reader aux_reader (.clock(clock), .rst_b(rst_b), .s(ser_aux));

   // ************************************************************
   // Step generator and pin drivers
   // ************************************************************
   logic [CNT_W-1:0] step_cnt_r, step_cnt_nxt;
   logic dir_r, dir_nxt;
   logic p2_r, p2_nxt, p2_oe_r, p2_oe_nxt, p4_r, p4_nxt, p4_oe_r, p4_oe_nxt;

   always_comb
   begin
      step_cnt_nxt = step_cnt_r;
      dir_nxt = dir_r;
      // A command that lands during a pulse must not stretch it.
      if (step_cnt_r != '0)
         step_cnt_nxt = step_cnt_r - 1'b1;
      if (wr_stb && (addr == OFS_STEP_CMD) && stepper)
      begin
         dir_nxt = wdata[STEP_DIR_BIT];
         if (wdata[STEP_FIRE_BIT] && step_cnt_r == '0)
            step_cnt_nxt = CNT_W'(STEP_PULSE_CYC);
      end
      p2_nxt = 1'b0;
      p2_oe_nxt = 1'b0;
      p4_nxt = 1'b0;
      p4_oe_nxt = 1'b0;
      if (stepper)
      begin
         p2_nxt = (step_cnt_nxt != '0);
         p2_oe_nxt = 1'b1;
         p4_nxt = dir_nxt;
         p4_oe_nxt = 1'b1;
      end
      else if (ser_active)
      begin
         p2_nxt = ser_main.sclk;
         p2_oe_nxt = 1'b1;
         p4_nxt = ser_aux.sclk;
         p4_oe_nxt = 1'b1;
      end
   end

   // ************************************************************
   // Register port
   // ************************************************************
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [1:0] gen_in;

   assign gen_in = stepper ? 2'h0 : {ab, aa};

   always_comb
   begin
      cfg_nxt = cfg_r;
      if (wr_stb && addr == OFS_CONFIG)
         cfg_nxt = wdata[4:0];
      rdata_nxt = '0;
      if (rd_stb)
      begin
         case (addr)
            OFS_CONFIG: rdata_nxt = {27'h0, cfg_r};
            OFS_MAIN_POS: rdata_nxt = pos_r;
            OFS_GEN_INPUTS: rdata_nxt = {30'h0, gen_in};
            OFS_STEP_CMD: rdata_nxt = {30'h0, dir_r, step_cnt_r != '0};
            OFS_SER_CTRL: rdata_nxt = {29'h0, opt, ser_aux.busy, ser_main.busy};
            OFS_MAIN_SER_POS: rdata_nxt = {8'h0, ser_main.word};
            OFS_AUX_SER_POS: rdata_nxt = {8'h0, ser_aux.word};
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         cfg_r <= CFG_RESET;
         pos_r <= '0;
         step_cnt_r <= '0;
         dir_r <= 1'b0;
         p2_r <= 1'b0;
         p2_oe_r <= 1'b0;
         p4_r <= 1'b0;
         p4_oe_r <= 1'b0;
         rdata_r <= '0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         pos_r <= pos_nxt;
         step_cnt_r <= step_cnt_nxt;
         dir_r <= dir_nxt;
         p2_r <= p2_nxt;
         p2_oe_r <= p2_oe_nxt;
         p4_r <= p4_nxt;
         p4_oe_r <= p4_oe_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;
   assign multi_pin_two_out = p2_r;
   assign multi_pin_two_oe = p2_oe_r;
   assign multi_pin_four_out = p4_r;
   assign multi_pin_four_oe = p4_oe_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   AST_QUAD_DEFAULT: assert property ($rose(rst_b) |-> enc_mode == ENC_QUAD)
      else $error("Encoder mode is not quadrature after reset.");
   AST_QUAD_COUNT: assert property ((enc_mode == ENC_QUAD && one_change) |=>
      pos_r == $past(pos_r) + ($past(quad_up) ? 32'h1 : 32'hffffffff))
      else $error("Quadrature edge not counted in the right direction.");
   AST_PD_COUNT: assert property ((enc_mode == ENC_PULSE_DIR && !one_change && ma && !pa_r)
      |=> pos_r == $past(pos_r) + ($past(mb) ? 32'h1 : 32'hffffffff))
      else $error("Step edge not counted with direction.");
   AST_PD_HOLD: assert property ((enc_mode == ENC_PULSE_DIR && !(ma && !pa_r))
      |=> pos_r == $past(pos_r))
      else $error("Count moved without a step edge.");
   AST_GEN_READ: assert property ((rd_stb && addr == OFS_GEN_INPUTS && !stepper)
      |=> rdata[1:0] == $past({ab, aa}))
      else $error("Inputs 81 and 82 do not follow the aux channels.");
   AST_AUX_OFF: assert property ((rd_stb && addr == OFS_GEN_INPUTS && stepper)
      |=> rdata[1:0] == 2'h0)
      else $error("Aux inputs visible in stepper mode.");
   AST_SER_GATE: assert property ((wr_ser && !ser_active && !ser_main.busy)
      |=> !ser_main.busy)
      else $error("Serial burst started without the option enabled.");
   AST_MAIN_CLK: assert property (ser_active ##1 ser_active
      |-> multi_pin_two_oe && multi_pin_two_out == $past(ser_main.sclk))
      else $error("Pin two does not carry the main serial clock.");
   AST_AUX_CLK: assert property (ser_active ##1 ser_active
      |-> multi_pin_four_oe && multi_pin_four_out == $past(ser_aux.sclk))
      else $error("Pin four does not carry the aux serial clock.");
   AST_STEP_PULSE: assert property ((wr_stb && addr == OFS_STEP_CMD && stepper
      && wdata[STEP_FIRE_BIT] && step_cnt_r == '0) |=> ##1 multi_pin_two_out [*8])
      else $error("Step pulse on pin two too short.");
   AST_PINS_IDLE: assert property ((!stepper && !ser_active)
      |=> !multi_pin_two_oe && !multi_pin_four_oe)
      else $error("Multi-function pins driven outside their modes.");

   COV_PD_MODE: cover property (enc_mode == ENC_PULSE_DIR && ma && !pa_r);
   COV_SER_DONE: cover property (ser_main.done);
   COV_STEP: cover property (stepper && multi_pin_two_out);
endmodule : enc_pin_top

// ===== sim/far_side_model.sv
/*
 * Far-side models: main and aux encoders, two serial absolute encoders, a stepper drive.
 * Assumes the bench calls the encoder tasks and wires the pins straight to the block.
 */
`timescale 1ns/100ps
module ser_enc_model #(
   parameter logic [23:0] WORD = 24'h000000
)
(
   input wire logic sclk,
   output logic sdata
);
   int idx = 0;
   realtime last_rise = -1.0e6;
   initial sdata = 1'b0;
   // A long high gap marks a new frame; outside frames the line is scrambled, not held.
   always @(negedge sclk)
   begin
      if ($realtime - last_rise > 1000.0)
         idx = 0;
      if (idx < 24)
         sdata = WORD[23 - idx];
      else
         sdata = ~sdata;
      idx = idx + 1;
   end
   always @(posedge sclk)
   begin
      last_rise = $realtime;
      if (idx == 24)
         sdata <= #200 ~sdata;
   end
endmodule : ser_enc_model

module far_side_model #(
   parameter logic [23:0] MAIN_WORD = 24'ha5c31e,
   parameter logic [23:0] AUX_WORD = 24'h3c96f0
)
(
   output logic main_a,
   output logic main_b,
   output logic aux_a,
   output logic aux_b,
   input wire logic pin_two_out,
   input wire logic pin_two_oe,
   input wire logic pin_four_out,
   input wire logic pin_four_oe,
   output logic pin_one_data,
   output logic pin_three_data
);
   logic main_clk;
   logic aux_clk;
   int step_count = 0;
   logic [1:0] up_seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
   logic [1:0] dn_seq [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
   initial {main_a, main_b, aux_a, aux_b} = 4'h0;
   // An undriven clock pair rests high, so no frame starts by accident.
   // Pin and enable flip in one step; both settle first, so their race fakes no edge.
   always @(pin_two_oe, pin_two_out, pin_four_oe, pin_four_out)
   begin
      #0;
      main_clk = pin_two_oe ? pin_two_out : 1'b1;
      aux_clk = pin_four_oe ? pin_four_out : 1'b1;
   end
   ser_enc_model #(.WORD(MAIN_WORD)) main_ser_i (.sclk(main_clk), .sdata(pin_one_data));
   ser_enc_model #(.WORD(AUX_WORD)) aux_ser_i (.sclk(aux_clk), .sdata(pin_three_data));
   always @(posedge pin_two_out)
      step_count = step_count + 1;
   // The offset keeps encoder edges away from the block's clock edges.
   task quad(input int n, input bit up);
      #7;
      repeat (n)
         for (int k = 0; k < 4; k++)
         begin
            {main_a, main_b} = up ? up_seq[k] : dn_seq[k];
            #80;
         end
   endtask : quad
   task pulse(input int n, input bit up);
      #7;
      main_b = up;
      #80;
      repeat (n)
      begin
         main_a = 1'b1;
         #80;
         main_a = 1'b0;
         #80;
      end
   endtask : pulse
   task aux(input bit a, input bit b);
      aux_a = a;
      aux_b = b;
   endtask : aux
endmodule : far_side_model

// ===== sim/tb_top.sv
/*
 * Self-checking bench for the encoder feedback and multi-function pin block.
 * Assumes the far-side model file and the design package are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
   import enc_pin_pkg::*;
   logic clock, rst_b, wr_stb, rd_stb, serial_encoder_option;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic ma, mb, aa, ab, p1, p3, p2o, p2e, p4o, p4e;
   int err_total = 0;
   int tests_run = 0;
   int fall2 = 0;
   int fall4 = 0;
   int step_high = 0;
   localparam logic [23:0] MW = 24'ha5c31e;
   localparam logic [23:0] AW = 24'h3c96f0;

   enc_pin_top enc_pin_top_i (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .main_enc_chan_a(ma),
      .main_enc_chan_b(mb), .aux_enc_chan_a(aa), .aux_enc_chan_b(ab),
      .serial_encoder_option(serial_encoder_option), .multi_pin_one_in(p1),
      .multi_pin_two_out(p2o), .multi_pin_two_oe(p2e), .multi_pin_three_in(p3),
      .multi_pin_four_out(p4o), .multi_pin_four_oe(p4e));
   far_side_model #(.MAIN_WORD(MW), .AUX_WORD(AW)) far_side_model_i (.main_a(ma), .main_b(mb),
      .aux_a(aa), .aux_b(ab), .pin_two_out(p2o), .pin_two_oe(p2e), .pin_four_out(p4o),
      .pin_four_oe(p4e), .pin_one_data(p1), .pin_three_data(p3));

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(negedge p2o) fall2 = fall2 + 1;
   always @(negedge p4o) fall4 = fall4 + 1;
   // Counting on the falling clock edge sees pin two well away from its launch.
   always @(negedge clock)
   begin
      if (p2o === 1'b1)
         step_high = step_high + 1;
   end

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task close_out;
      if (err_total == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   task check32(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check32
   task check1(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : check1
   task reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask : reg_wr
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1;
      check32(rdata, exp, what);
   endtask : rd_chk
   task cycles(input int n);
      repeat (n) @(posedge clock);
   endtask : cycles

   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_counting;
      rd_chk(OFS_CONFIG, 32'h0, "config after reset");
      check1(p2e | p4e, 1'b0, "pins released after reset");
      far_side_model_i.quad(3, 1'b1);
      cycles(5);
      rd_chk(OFS_MAIN_POS, 32'd12, "quad forward");
      far_side_model_i.quad(2, 1'b0);
      cycles(5);
      rd_chk(OFS_MAIN_POS, 32'd4, "quad reverse");
      reg_wr(OFS_CONFIG, 32'h1);
      far_side_model_i.pulse(5, 1'b1);
      cycles(5);
      rd_chk(OFS_MAIN_POS, 32'd9, "pulse up");
      far_side_model_i.pulse(3, 1'b0);
      cycles(5);
      rd_chk(OFS_MAIN_POS, 32'd6, "pulse down");
      reg_wr(OFS_CONFIG, 32'h0);
      far_side_model_i.quad(1, 1'b1);
      cycles(5);
      rd_chk(OFS_MAIN_POS, 32'd10, "quad again");
   endtask : t_counting
   task t_aux_step;
      int hi;
      int base;
      logic dir;
      far_side_model_i.aux(1'b1, 1'b0);
      cycles(5);
      rd_chk(OFS_GEN_INPUTS, 32'h1, "input 81");
      far_side_model_i.aux(1'b0, 1'b1);
      cycles(5);
      rd_chk(OFS_GEN_INPUTS, 32'h2, "input 82");
      far_side_model_i.aux(1'b1, 1'b1);
      base = far_side_model_i.step_count;
      for (int i = 2; i < 6; i++)
      begin
         dir = i[0];
         reg_wr(OFS_CONFIG, 32'(i) << CFG_MT_LSB);
         rd_chk(OFS_GEN_INPUTS, 32'h0, "aux hidden in stepper");
         hi = step_high;
         reg_wr(OFS_STEP_CMD, {30'h0, dir, 1'b1});
         reg_wr(OFS_STEP_CMD, {30'h0, dir, 1'b1});
         cycles(100);
         check32(32'(step_high - hi), 32'(STEP_PULSE_CYC), "step width");
         check1(p4o, dir, "direction pin");
         check1(p2e & p4e, 1'b1, "step pins driven");
      end
      check32(32'(far_side_model_i.step_count - base), 32'd4, "steps seen");
      reg_wr(OFS_CONFIG, 32'h4);
      reg_wr(OFS_STEP_CMD, 32'h1);
      cycles(60);
      check32(32'(far_side_model_i.step_count - base), 32'd4, "servo no step");
      rd_chk(OFS_GEN_INPUTS, 32'h3, "aux back in servo");
   endtask : t_aux_step
   task t_serial;
      reg_wr(OFS_CONFIG, 32'h2);
      reg_wr(OFS_SER_CTRL, 32'h1);
      cycles(5);
      rd_chk(OFS_SER_CTRL, 32'h0, "no option no burst");
      serial_encoder_option <= 1'b1;
      reg_wr(OFS_CONFIG, 32'h0);
      cycles(3);
      reg_wr(OFS_SER_CTRL, 32'h1);
      cycles(5);
      rd_chk(OFS_SER_CTRL, 32'h4, "disabled no burst");
      reg_wr(OFS_CONFIG, 32'h2);
      fall2 = 0;
      fall4 = 0;
      reg_wr(OFS_SER_CTRL, 32'h1);
      cycles(2);
      rd_chk(OFS_SER_CTRL, 32'h5, "main busy");
      cycles(1300);
      check32(32'(fall2), 32'd24, "main clock count");
      check32(32'(fall4), 32'd0, "pin four quiet");
      rd_chk(OFS_MAIN_SER_POS, {8'h00, MW}, "main word");
      cycles(1000);
      fall2 = 0;
      fall4 = 0;
      reg_wr(OFS_SER_CTRL, 32'h2);
      cycles(2);
      rd_chk(OFS_SER_CTRL, 32'h6, "aux busy");
      cycles(1300);
      check32(32'(fall4), 32'd24, "aux clock count");
      check32(32'(fall2), 32'd0, "pin two quiet");
      rd_chk(OFS_AUX_SER_POS, {8'h00, AW}, "aux word");
   endtask : t_serial

   initial
   begin
      rst_b = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = '0;
      wdata = '0;
      serial_encoder_option = 1'b0;
      cycles(20);
      rst_b <= 1'b1;
      t_counting();
      t_aux_step();
      t_serial();
      close_out();
   end
   initial
   begin
      cycles(40000);
      err_total++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end
endmodule : tb_top
